// ===== dv/test_windowed_watchdog_control.sv
// Purpose: Self-checking bench for the watchdog control registers and window timer
// Assumes: AXI4-Lite master tasks below; config held steady across each reset
// Notes: Only the 31 kHz source is timed, to keep the run under 100k cycles
`include "wdc_consts.svh"

module test_windowed_watchdog_control
    import wdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Aclk ticks per low oscillator tick
    localparam int LOW_TICK = 1613;

    // Clock, reset and bus drive, all given a value at time zero
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    // Configuration word, fields sampled by the design at its reset edge, enable code read every cycle
    logic [4:0] cfg_prescale_field = 5'h1f;
    logic [2:0] cfg_clock_field = 3'h7;
    logic [2:0] cfg_window_field = 3'h7;
    logic [1:0] hw_enable_cfg = 2'h1;
    logic clear_request = 1'b0;
    logic timeout_pulse;
    logic window_open;
    logic timer_running;
    // Counters for the verdict and for interval timing
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    int i;
    logic [1:0] resp;

    // 50 MHz clock
    always #10 aclk = ~aclk;

    // Free-running cycle count, read only at edges so both ends agree
    always @(posedge aclk) cyc <= cyc + 1;

    wdc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .cfg_prescale_field(cfg_prescale_field), .cfg_clock_field(cfg_clock_field),
        .cfg_window_field(cfg_window_field), .hw_enable_cfg(hw_enable_cfg), .clear_request(clear_request),
        .timeout_pulse(timeout_pulse), .window_open(window_open), .timer_running(timer_running));

    // Verdict and end of run, the only exit
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Single comparison point; case inequality so unknowns fail
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // A bound ran out: count it and stop
    task automatic hang(input string what);
        n_errors++;
        $display("mismatch %s expected event seen timeout", what);
        tally_and_finish();
    endtask : hang

    // Write: AW and W offered together, each dropped once taken
    task automatic axi_write(input logic [3:0] addr, input logic [7:0] data, input logic [3:0] strb);
        int k;
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, data};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            // Each channel released only at its own taken edge
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            // Bready held high, so bvalid seen here completes the response
            if (s_axi_bvalid === 1'b1)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write response");
    endtask : axi_write

    // Read: address held until taken, rready held until rvalid
    task automatic axi_read(input logic [3:0] addr, output logic [31:0] data);
        int k;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
            begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1)
            begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read response");
    endtask : axi_read

    // Read a register, compare data and response code
    task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic [31:0] d;
        axi_read(addr, d);
        check($sformatf("read data at %h", addr), d, exp);
        check($sformatf("read resp at %h", addr), {30'h0, resp}, {30'h0, exp_resp});
    endtask : rd_chk

    // Full-strobe write expecting OKAY
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        axi_write(addr, data, 4'hf);
        check($sformatf("write resp at %h", addr), {30'h0, resp}, 32'h0000_0000);
    endtask : wr

    // Bounded wait for an output level: 0 window, 1 timeout, 2 running
    task automatic wait_sig(input int kind, input logic level, input int bound, input string what);
        int k;
        for (k = 0; k < bound; k++)
        begin
            @(posedge aclk);
            if ((kind == 0 ? window_open : kind == 1 ? timeout_pulse : timer_running) === level)
            begin
                return;
            end
        end
        hang(what);
    endtask : wait_sig

    // Reset with a given configuration word, held 20 cycles
    task automatic do_reset(input logic [4:0] ps, input logic [2:0] cs, input logic [2:0] win,
        input logic [1:0] hw);
        @(posedge aclk);
        aresetn <= 1'b0;
        cfg_prescale_field <= ps;
        cfg_clock_field <= cs;
        cfg_window_field <= win;
        hw_enable_cfg <= hw;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    // Main sequence
    initial
    begin
        // All fields open, software enable honoured
        do_reset(5'h1f, 3'h7, 3'h7, 2'h1);
        rd_chk(`WDC_OFF_CTRL0, 32'h0000_0016, 2'h0);
        rd_chk(`WDC_OFF_CTRL1, 32'h0000_0007, 2'h0);
        // Every prescale code, with the unused top bits set on write
        for (i = 0; i < 32; i++)
        begin
            wr(`WDC_OFF_CTRL0, {2'b11, i[4:0], 1'b0});
            rd_chk(`WDC_OFF_CTRL0, {26'h0, i[4:0], 1'b0}, 2'h0);
        end
        // Every clock and window code, with bits 7 and 3 set on write
        for (i = 0; i < 8; i++)
        begin
            wr(`WDC_OFF_CTRL1, {1'b1, i[2:0], 1'b1, i[2:0]});
            rd_chk(`WDC_OFF_CTRL1, {25'h0, i[2:0], 1'b0, i[2:0]}, 2'h0);
        end
        // Byte lane disabled: register keeps code 31
        axi_write(`WDC_OFF_CTRL0, 8'h02, 4'h0);
        rd_chk(`WDC_OFF_CTRL0, 32'h0000_003e, 2'h0);
        // Unmapped word answers with an error and zero data
        axi_write(4'hc, 8'h55, 4'hf);
        check("unmapped write resp", {30'h0, resp}, 32'h0000_0002);
        rd_chk(4'hc, 32'h0000_0000, 2'h2);
        // Software enable switches the timer under config 01
        wr(`WDC_OFF_CTRL0, 8'h01);
        wait_sig(2, 1'b1, 10, "timer start");
        wr(`WDC_OFF_CTRL0, 8'h00);
        wait_sig(2, 1'b0, 10, "timer stop");
        // Low oscillator, window 000: open for the last 4 of 32 ticks
        wr(`WDC_OFF_CTRL1, 8'h00);
        wr(`WDC_OFF_CTRL0, 8'h01);
        wait_sig(0, 1'b1, 60000, "window open 000");
        t0 = cyc;
        // Window 110 for the next period, still open now
        wr(`WDC_OFF_CTRL1, 8'h06);
        wait_sig(1, 1'b1, 8000, "period end");
        check("open to timeout", 32'((cyc - t0) >= 4 * LOW_TICK - 2 && (cyc - t0) <= 4 * LOW_TICK + 2), 1);
        t0 = cyc;
        // Window 110: closed for the first 4 ticks of the period
        wait_sig(0, 1'b0, 40, "window close");
        wait_sig(0, 1'b1, 8000, "window open 110");
        check("timeout to open", 32'((cyc - t0) >= 4 * LOW_TICK - 2 && (cyc - t0) <= 4 * LOW_TICK + 2), 1);
        // Clear restarts the count, so the window shuts again
        clear_request <= 1'b1;
        wait_sig(0, 1'b0, 10, "window close on clear");
        clear_request <= 1'b0;
        // Locked fields: reset loads the config word, writes bounce off
        do_reset(5'h05, 3'h1, 3'h3, 2'h0);
        rd_chk(`WDC_OFF_CTRL0, 32'h0000_000a, 2'h0);
        rd_chk(`WDC_OFF_CTRL1, 32'h0000_0013, 2'h0);
        wr(`WDC_OFF_CTRL0, 8'hff);
        rd_chk(`WDC_OFF_CTRL0, 32'h0000_000b, 2'h0);
        wr(`WDC_OFF_CTRL1, 8'hff);
        rd_chk(`WDC_OFF_CTRL1, 32'h0000_0013, 2'h0);
        // Soft enable set but hardware config 00 keeps the timer off
        repeat (5) @(posedge aclk);
        check("running with config off", {31'h0, timer_running}, 32'h0000_0000);
        // Config 10 runs the timer with soft enable clear
        do_reset(5'h05, 3'h1, 3'h3, 2'h2);
        wait_sig(2, 1'b1, 10, "timer forced on");
        // Status is read-only: running, window shut, enable forced on
        wr(`WDC_OFF_STAT, 8'h00);
        rd_chk(`WDC_OFF_STAT, 32'h0000_0005, 2'h0);
        tally_and_finish();
    end

endmodule : test_windowed_watchdog_control

// ===== verilog/wdc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the watchdog control block
// Assumes: 50 MHz aclk, AXI4-Lite register access
// Notes: Included by bare name; guarded against double inclusion
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

// Register byte addresses
`define WDC_OFF_CTRL0 4'h0
`define WDC_OFF_CTRL1 4'h4
`define WDC_OFF_STAT 4'h8

// Control register 0 fields
`define WDC_PS_LSB 1
`define WDC_PS_MSB 5
`define WDC_SEN_BIT 0
// Control register 1 fields
`define WDC_CS_LSB 4
`define WDC_CS_MSB 6
`define WDC_WIN_LSB 0
`define WDC_WIN_MSB 2

// Configuration codes that unlock the fields, and the hardware enable codes
`define WDC_CFG_PS_OPEN 5'h1f
`define WDC_CFG_CS_OPEN 3'h7
`define WDC_CFG_WIN_OPEN 3'h7
`define WDC_HWEN_SOFT 2'h1
`define WDC_HWEN_OFF 2'h0

// Reset values
`define WDC_PS_RESET 5'h0b
`define WDC_CS_RESET 3'h0
`define WDC_SEN_RESET 1'b0

// Prescale coding
`define WDC_PS_MAX_CODE 5'h12
`define WDC_PS_BASE_EXP 5'h05

// Clock source codes
`define WDC_CS_LOW 3'h0
`define WDC_CS_MID 3'h1

// Timing: rates in Hz, divide counts derived by rounding to nearest
`define WDC_CLK_HZ 50000000
`define WDC_LOW_OSC_HZ 31000
`define WDC_MID_OSC_HZ 31250
`define WDC_LOW_DIV ((`WDC_CLK_HZ + `WDC_LOW_OSC_HZ / 2) / `WDC_LOW_OSC_HZ)
`define WDC_MID_DIV ((`WDC_CLK_HZ + `WDC_MID_OSC_HZ / 2) / `WDC_MID_OSC_HZ)

// AXI responses
`define WDC_RESP_OKAY 2'h0
`define WDC_RESP_SLVERR 2'h2

`endif

// ===== verilog/wdc_divider.sv
// Purpose: Divides aclk into a one-cycle tick at an oscillator rate
// Assumes: DIVIDE between 2 and 2047
// Notes: Tick is a clock enable, never a clock
`include "wdc_consts.svh"

module wdc_divider
    import wdc_pkg::*;
#(
    parameter logic [10:0] DIVIDE = 11'h064
)
(
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);

    wdc_div_state_type state; // Registered state
    wdc_div_state_type next_state; // Next state

    // Count down the period, pulse on wrap
    always_comb
    begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count == 11'h000)
        begin
            next_state.count = DIVIDE - 11'h001;
            next_state.tick = 1'b1;
        end
        else
        begin
            next_state.count = state.count - 11'h001;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : wdc_divider

// ===== verilog/wdc_pkg.sv
// Purpose: Types shared by the watchdog control files
// Assumes: Constants come from wdc_consts.svh
// Notes: All module state is held in the packed structs below
package wdc_pkg;

    // Timer phase, Gray along off, delay, open
    typedef enum logic [1:0] {
        wdc_off = 2'h0,
        wdc_delay = 2'h1,
        wdc_open = 2'h3
    } wdc_phase_type;

    // Tick divider state
    typedef struct packed {
        logic [10:0] count;
        logic tick;
    } wdc_div_state_type;

    // Control block state
    typedef struct packed {
        logic [4:0] prescale;
        logic soft_enable;
        logic [2:0] clock_sel;
        logic [2:0] window;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [22:0] count;
        wdc_phase_type phase;
        logic timeout;
        logic running;
    } wdc_state_type;

endpackage : wdc_pkg

// ===== verilog/wdc_top.sv
// Purpose: Windowed watchdog control registers with prescaled window timer
// Assumes: Configuration inputs steady; AXI4-Lite master obeys handshakes
// Notes: Timeout is reported only; reset generation lives elsewhere
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`include "wdc_consts.svh"

module wdc_top
    import wdc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] cfg_prescale_field,
    input wire logic [2:0] cfg_clock_field,
    input wire logic [2:0] cfg_window_field,
    input wire logic [1:0] hw_enable_cfg,
    input wire logic clear_request,
    output logic timeout_pulse,
    output logic window_open,
    output logic timer_running
);

    wdc_state_type state; // Registered state
    wdc_state_type next_state; // Next state
    logic low_tick; // 31 kHz enable
    logic mid_tick; // 31.25 kHz enable
    logic tick; // Selected timer enable
    logic [4:0] exp_sel; // Period as power of two
    logic [22:0] last_count; // Terminal count
    logic [22:0] shifted; // Count scaled to eighths
    logic [2:0] eighth; // Current eighth of period
    logic active; // Effective enable
    logic do_write; // Write commits this cycle
    logic ps_write; // Prescale changed by software
    logic [7:0] rd_byte; // Selected read byte
    logic rd_err; // Unmapped read

    // Oscillator rate enables
    wdc_divider #(
        .DIVIDE(11'(`WDC_LOW_DIV))
    ) u_low_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(low_tick)
    );

    wdc_divider #(
        .DIVIDE(11'(`WDC_MID_DIV))
    ) u_mid_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(mid_tick)
    );

    // Source select; reserved codes give no tick, so the count holds
    always_comb
    begin
        unique case (state.clock_sel)
            `WDC_CS_LOW: tick = low_tick;
            `WDC_CS_MID: tick = mid_tick;
            default: tick = 1'b0;
        endcase
    end

    // Code to exponent: 1:32 at zero, reserved codes fall back to 1:32
    always_comb
    begin
        if (state.prescale > `WDC_PS_MAX_CODE)
        begin
            exp_sel = `WDC_PS_BASE_EXP;
        end
        else
        begin
            exp_sel = state.prescale + `WDC_PS_BASE_EXP;
        end
        last_count = 23'((24'h00_0001 << exp_sel) - 24'h00_0001);
        shifted = state.count >> (exp_sel - 5'h03);
        eighth = shifted[2:0];
    end

    // Hardware config 1x forces on, 00 off, 01 defers to software
    always_comb
    begin
        if (hw_enable_cfg == `WDC_HWEN_SOFT)
        begin
            active = state.soft_enable;
        end
        else
        begin
            active = hw_enable_cfg[1];
        end
    end

    // Write commits once address and data are both held
    assign do_write = state.aw_held && state.w_held && !state.bvalid;
    assign ps_write = do_write && state.w_lane0 && (state.aw_addr == `WDC_OFF_CTRL0)
        && (cfg_prescale_field == `WDC_CFG_PS_OPEN);

    // Read mux; unused bits stay zero
    always_comb
    begin
        rd_byte = 8'h00;
        rd_err = 1'b0;
        unique case (s_axi_araddr)
            `WDC_OFF_CTRL0:
            begin
                rd_byte[`WDC_PS_MSB:`WDC_PS_LSB] = state.prescale;
                rd_byte[`WDC_SEN_BIT] = state.soft_enable;
            end
            `WDC_OFF_CTRL1:
            begin
                rd_byte[`WDC_CS_MSB:`WDC_CS_LSB] = state.clock_sel;
                rd_byte[`WDC_WIN_MSB:`WDC_WIN_LSB] = state.window;
            end
            `WDC_OFF_STAT:
            begin
                rd_byte[0] = state.running;
                rd_byte[1] = (state.phase == wdc_open);
                rd_byte[2] = active;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    // Next state: bus slave, register file, window timer
    always_comb
    begin
        next_state = state;
        next_state.timeout = 1'b0;
        // Write address channel
        if (s_axi_awvalid && state.awready)
        begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        // Write data channel; only lane 0 carries register bits
        if (s_axi_wvalid && state.wready)
        begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata[7:0];
            next_state.w_lane0 = s_axi_wstrb[0];
        end
        // Commit; locked fields keep their value
        if (do_write)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = `WDC_RESP_OKAY;
            if (state.aw_addr == `WDC_OFF_CTRL0)
            begin
                if (state.w_lane0)
                begin
                    next_state.soft_enable = state.w_data[`WDC_SEN_BIT];
                    if (cfg_prescale_field == `WDC_CFG_PS_OPEN)
                    begin
                        next_state.prescale = state.w_data[`WDC_PS_MSB:`WDC_PS_LSB];
                    end
                end
            end
            else if (state.aw_addr == `WDC_OFF_CTRL1)
            begin
                if (state.w_lane0 && cfg_clock_field == `WDC_CFG_CS_OPEN)
                begin
                    next_state.clock_sel = state.w_data[`WDC_CS_MSB:`WDC_CS_LSB];
                end
                if (state.w_lane0 && cfg_window_field == `WDC_CFG_WIN_OPEN)
                begin
                    next_state.window = state.w_data[`WDC_WIN_MSB:`WDC_WIN_LSB];
                end
            end
            else if (state.aw_addr != `WDC_OFF_STAT)
            begin
                next_state.bresp = `WDC_RESP_SLVERR;
            end
        end
        // Write response
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end
        // Channels stall while a beat is held or a response pends
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready = !next_state.w_held && !next_state.bvalid;
        // Read: answer one cycle after the address is taken
        if (s_axi_arvalid && state.arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata = {24'h00_0000, rd_byte};
            next_state.rresp = rd_err ? `WDC_RESP_SLVERR : `WDC_RESP_OKAY;
        end
        else if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
        next_state.arready = !next_state.rvalid;
        // Timer restarts on disable, clear or new ratio
        next_state.running = active;
        if (!active || clear_request || ps_write)
        begin
            next_state.count = 23'h00_0000;
        end
        else if (tick)
        begin
            if (state.count == last_count)
            begin
                next_state.count = 23'h00_0000;
                next_state.timeout = 1'b1;
            end
            else
            begin
                next_state.count = state.count + 23'h00_0001;
            end
        end
        // Closed for the first 7 - code eighths of the period
        unique case (state.phase)
            wdc_off:
            begin
                if (active)
                begin
                    next_state.phase = wdc_delay;
                end
            end
            wdc_delay, wdc_open:
            begin
                if (!active)
                begin
                    next_state.phase = wdc_off;
                end
                else if (eighth >= 3'h7 - state.window)
                begin
                    next_state.phase = wdc_open;
                end
                else
                begin
                    next_state.phase = wdc_delay;
                end
            end
            default:
            begin
                next_state.phase = wdc_off;
            end
        endcase
    end

    // Register; reset loads the window, and prescale and clock select unless open, from the configuration word
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= '0;
            state.soft_enable <= `WDC_SEN_RESET;
            // Sync reset, so sampling the static config here is safe
            if (cfg_prescale_field == `WDC_CFG_PS_OPEN)
            begin
                state.prescale <= `WDC_PS_RESET;
            end
            else
            begin
                state.prescale <= cfg_prescale_field;
            end
            if (cfg_clock_field == `WDC_CFG_CS_OPEN)
            begin
                state.clock_sel <= `WDC_CS_RESET;
            end
            else
            begin
                state.clock_sel <= cfg_clock_field;
            end
            state.window <= cfg_window_field;
            state.phase <= wdc_off;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign timeout_pulse = state.timeout;
    // Phase bit 1 is set only in the open state, so the pin is a bare flop bit
    assign window_open = state.phase[1];
    assign timer_running = state.running;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ps_reset_load: assert property (disable iff (1'b0) !aresetn |=>
        state.prescale == (($past(cfg_prescale_field) == `WDC_CFG_PS_OPEN) ? `WDC_PS_RESET
        : $past(cfg_prescale_field)))
        else $error("prescale reset value wrong");
    a_cs_reset_load: assert property (disable iff (1'b0) !aresetn |=>
        state.clock_sel == (($past(cfg_clock_field) == `WDC_CFG_CS_OPEN) ? `WDC_CS_RESET
        : $past(cfg_clock_field)))
        else $error("clock select reset value wrong");
    a_win_reset_load: assert property (disable iff (1'b0) !aresetn |=>
        state.window == $past(cfg_window_field))
        else $error("window reset value wrong");
    a_ps_locked: assert property ((cfg_prescale_field != `WDC_CFG_PS_OPEN) |=>
        $stable(state.prescale))
        else $error("locked prescale changed");
    a_ps_write_lands: assert property (ps_write |=>
        state.prescale == $past(state.w_data[`WDC_PS_MSB:`WDC_PS_LSB]))
        else $error("prescale write lost");
    a_cs_locked: assert property ((cfg_clock_field != `WDC_CFG_CS_OPEN) |=>
        $stable(state.clock_sel))
        else $error("locked clock select changed");
    a_win_locked: assert property ((cfg_window_field != `WDC_CFG_WIN_OPEN) |=>
        $stable(state.window))
        else $error("locked window changed");
    // Gated by reset so the edge that releases it, which still clears running, is not checked
    a_soft_ignored: assert property ((hw_enable_cfg != `WDC_HWEN_SOFT) && aresetn |=>
        timer_running == $past(hw_enable_cfg[1]))
        else $error("soft enable not ignored");
    a_reserved_zero: assert property ((s_axi_rvalid && !$past(s_axi_rvalid)) |->
        s_axi_rdata[31:7] == 25'h000_0000 && (s_axi_rdata[3] == 1'b0 || !$past(s_axi_araddr[2])))
        else $error("unimplemented bits not zero");
    // Off goes to delay first, so the window is seen open one edge after two enabled edges
    a_window_full: assert property ((state.window == 3'h7 && active) [*2] |=>
        window_open)
        else $error("full window not open");
    a_timeout_wrap: assert property (timeout_pulse |-> state.count == 23'h00_0000
        && $past(state.count) == $past(last_count))
        else $error("timeout not at terminal count");
    a_reserved_src: assert property ((state.clock_sel > `WDC_CS_MID && active && !clear_request) [*2]
        |-> $stable(state.count))
        else $error("reserved source counted");

    c_timeout: cover property (timeout_pulse);
    c_window_opens: cover property (!window_open ##1 window_open);
    c_ps_write: cover property (ps_write);
    c_read_err: cover property (s_axi_rvalid && s_axi_rresp == `WDC_RESP_SLVERR);

endmodule : wdc_top
